// ===== rtl/pfs_pkg.sv
// Constants, register map and carrier types of the port A pin function select
package pfs_pkg;

  // ***********************************************************************
  // Register map
  // ***********************************************************************
  // Byte addresses; both halfword registers travel on data bits 15:0
  localparam logic [31:0] FUNC_ADDR  = 32'hFFFFFC80;
  localparam logic [31:0] DIR_ADDR   = 32'hFFFFFC82;

  // ***********************************************************************
  // Field layout and reset values
  // ***********************************************************************
  localparam int          NUM_PINS   = 14;
  localparam logic [15:0] FUNC_RST   = 16'h0000;
  localparam logic [15:0] DIR_RST    = 16'h0000;
  localparam logic [15:0] FUNC_WMASK = 16'h3FFF;
  localparam logic [15:0] DIR_WMASK  = 16'h3FF7;
  // Pin 7 is general I/O when its selector bit is set
  localparam logic [13:0] FUNC_INV   = 14'h0080;
  // Pin 3 has no general I/O function
  localparam logic [13:0] GPIO_CAP   = 14'h3FF7;
  // Watchdog overflow and peripheral clock pins drive from reset
  localparam logic [13:0] PAD_OE_RST = 14'h0088;
  localparam logic [13:0] PAD_OUT_RST = 14'h0000;
  localparam logic [31:0] RDATA_RST  = 32'h00000000;

  // ***********************************************************************
  // Pin positions
  // ***********************************************************************
  localparam int PIN_RX_CLK   = 13;
  localparam int PIN_RX_SYNC  = 12;
  localparam int PIN_RX_DATA  = 11;
  localparam int PIN_TX_CLK   = 10;
  localparam int PIN_TX_SYNC  = 9;
  localparam int PIN_TX_DATA  = 8;
  localparam int PIN_WDOG     = 7;
  localparam int PIN_TMR_CLK  = 6;
  localparam int PIN_TMR_CAP  = 5;
  localparam int PIN_TMR_CMPA = 4;
  localparam int PIN_CLK_CMPB = 3;
  localparam int PIN_ETH_LINK = 2;
  localparam int PIN_ETH_OUT  = 1;
  localparam int PIN_ETH_CAM  = 0;

  // ***********************************************************************
  // Carrier types
  // ***********************************************************************
  typedef struct packed {
    logic serial_tx_sync_out;
    logic serial_tx_sync_oe;
    logic serial_tx_data_out;
    logic watchdog_overflow_out;
    logic timer_compare_out_a;
    logic timer_compare_out_b;
    logic peripheral_clock_out;
    logic ethernet_general_out;
  } pfs_periph_drive_s;

  typedef struct packed {
    logic serial_rx_clock_in;
    logic serial_rx_sync_in;
    logic serial_rx_data_in;
    logic serial_tx_clock;
    logic serial_tx_sync_in;
    logic timer_ext_clock_in;
    logic timer_capture_in;
    logic ethernet_link_status_in;
    logic ethernet_match_sense_in;
  } pfs_periph_sense_s;

  typedef struct packed {
    logic [15:0]       func;
    logic [15:0]       dir;
    logic [13:0]       sync1;
    logic [13:0]       sync2;
    logic [13:0]       pad_out;
    logic [13:0]       pad_oe;
    logic [13:0]       gpio_in;
    pfs_periph_sense_s sense;
    logic              ack;
    logic [31:0]       rdata;
  } pfs_state_s;

endpackage

// ===== rtl/pfs_pin_select.sv
// Port A pin function select with Wishbone register slave
`timescale 1ns/100ps
// Summary of operation
// - Function register: sixteen bits, read/write, one selector per pin.
// - Function register clears only at power-on reset, kept otherwise.
// - Function bits 15 and 14 read zero; software writes zero.
// - Bit 13: general I/O at 0, serial receive clock input at 1.
// - Bit 12: general I/O at 0, serial receive sync input at 1.
// - Bit 11: general I/O at 0, serial receive data input at 1.
// - Bit 10: general I/O at 0, serial transmit clock at 1.
// - Bit 9: general I/O at 0, bidirectional transmit sync at 1.
// - Bit 8: general I/O at 0, serial transmit data output at 1.
// - Bit 7: watchdog overflow output at 0, general I/O at 1.
// - Bit 6: general I/O at 0, timer external clock input at 1.
// - Bit 5: general I/O at 0, timer capture input at 1.
// - Bit 4: general I/O at 0, timer compare output A at 1.
// - Bit 3: peripheral clock output at 0, compare output B at 1.
// - Bit 2: general I/O at 0, Ethernet link status input at 1.
// - Bit 1: general I/O at 0, Ethernet general output at 1.
// - Bit 0: general I/O at 0, Ethernet match sense input at 1.
// - Direction register: sixteen bits, one bit per general I/O pin.
// - Direction bit ignored while its pin carries a peripheral function.
// - General I/O pin drives when direction is 1, input when 0.
// - Direction register clears only at power-on reset.
// - Both registers reset to zero, byte and halfword access allowed.
module pfs_pin_select (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [31:0]                 wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  input  wire logic [13:0]                 pad_in_i,
  output logic      [13:0]                 pad_out_o,
  output logic      [13:0]                 pad_oe_o,
  input  wire logic [13:0]                 gpio_out_i,
  output logic      [13:0]                 gpio_in_o,
  input  wire pfs_pkg::pfs_periph_drive_s  drive_i,
  output pfs_pkg::pfs_periph_sense_s       sense_o
);

  // ***********************************************************************
  // State and decode
  // ***********************************************************************
  pfs_pkg::pfs_state_s st_reg;
  pfs_pkg::pfs_state_s st_next;

  logic        wb_req;
  logic        hit_func;
  logic        hit_dir;
  logic [13:0] periph_out_w;
  logic [13:0] periph_oe_w;
  logic [13:0] gpio_mode_w;
  logic [13:0] mux_out_w;
  logic [13:0] mux_oe_w;
  logic [13:0] sel_w;

  // Answer once per request; ack high blocks a double write
  assign wb_req   = wb_cyc_i & wb_stb_i & ~st_reg.ack;
  assign hit_func = (wb_adr_i == pfs_pkg::FUNC_ADDR);
  assign hit_dir  = (wb_adr_i == pfs_pkg::DIR_ADDR);
  assign sel_w    = st_reg.func[13:0];

  // ***********************************************************************
  // Peripheral side of each pin
  // ***********************************************************************
  // Receive-only functions never drive the pad
  assign periph_out_w = {
    1'b0,
    1'b0,
    1'b0,
    1'b0,
    drive_i.serial_tx_sync_out,
    drive_i.serial_tx_data_out,
    drive_i.watchdog_overflow_out,
    1'b0,
    1'b0,
    drive_i.timer_compare_out_a,
    sel_w[pfs_pkg::PIN_CLK_CMPB] ? drive_i.timer_compare_out_b
                                 : drive_i.peripheral_clock_out,
    1'b0,
    drive_i.ethernet_general_out,
    1'b0
  };

  assign periph_oe_w = {
    4'b0000,
    drive_i.serial_tx_sync_oe,
    1'b1,
    1'b1,
    2'b00,
    1'b1,
    1'b1,
    1'b0,
    1'b1,
    1'b0
  };

  // ***********************************************************************
  // Per-pin multiplexer
  // ***********************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < pfs_pkg::NUM_PINS; gi = gi + 1) begin : g_pin
      assign gpio_mode_w[gi] = pfs_pkg::GPIO_CAP[gi] &
        ~(sel_w[gi] ^ pfs_pkg::FUNC_INV[gi]);
      assign mux_out_w[gi] = gpio_mode_w[gi] ? gpio_out_i[gi]
                                             : periph_out_w[gi];
      assign mux_oe_w[gi]  = gpio_mode_w[gi] ? st_reg.dir[gi]
                                             : periph_oe_w[gi];
    end
  endgenerate

  // ***********************************************************************
  // Next state
  // ***********************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.ack = wb_req;
    st_next.rdata = pfs_pkg::RDATA_RST;
    if (wb_req && wb_we_i && hit_func) begin
      if (wb_sel_i[0]) begin
        st_next.func[7:0] = wb_dat_i[7:0] &
                            pfs_pkg::FUNC_WMASK[7:0];
      end
      if (wb_sel_i[1]) begin
        st_next.func[15:8] = wb_dat_i[15:8] &
                             pfs_pkg::FUNC_WMASK[15:8];
      end
    end
    if (wb_req && wb_we_i && hit_dir) begin
      if (wb_sel_i[0]) begin
        st_next.dir[7:0] = wb_dat_i[7:0] &
                           pfs_pkg::DIR_WMASK[7:0];
      end
      if (wb_sel_i[1]) begin
        st_next.dir[15:8] = wb_dat_i[15:8] &
                            pfs_pkg::DIR_WMASK[15:8];
      end
    end
    // Unmapped reads answer zero rather than stall the bus
    if (wb_req && !wb_we_i) begin
      if (hit_func) begin
        st_next.rdata = {16'h0000, st_reg.func};
      end else if (hit_dir) begin
        st_next.rdata = {16'h0000, st_reg.dir};
      end
    end
    // Pads pass two flops before anything looks at them
    st_next.sync1   = pad_in_i;
    st_next.sync2   = st_reg.sync1;
    st_next.gpio_in = st_reg.sync2;
    st_next.pad_out = mux_out_w;
    st_next.pad_oe  = mux_oe_w;
    // Unselected peripheral inputs see a quiet zero
    st_next.sense.serial_rx_clock_in = st_reg.sync2[pfs_pkg::PIN_RX_CLK] &
      sel_w[pfs_pkg::PIN_RX_CLK];
    st_next.sense.serial_rx_sync_in = st_reg.sync2[pfs_pkg::PIN_RX_SYNC] &
      sel_w[pfs_pkg::PIN_RX_SYNC];
    st_next.sense.serial_rx_data_in = st_reg.sync2[pfs_pkg::PIN_RX_DATA] &
      sel_w[pfs_pkg::PIN_RX_DATA];
    st_next.sense.serial_tx_clock = st_reg.sync2[pfs_pkg::PIN_TX_CLK] &
      sel_w[pfs_pkg::PIN_TX_CLK];
    st_next.sense.serial_tx_sync_in = st_reg.sync2[pfs_pkg::PIN_TX_SYNC] &
      sel_w[pfs_pkg::PIN_TX_SYNC];
    st_next.sense.timer_ext_clock_in = st_reg.sync2[pfs_pkg::PIN_TMR_CLK] &
      sel_w[pfs_pkg::PIN_TMR_CLK];
    st_next.sense.timer_capture_in = st_reg.sync2[pfs_pkg::PIN_TMR_CAP] &
      sel_w[pfs_pkg::PIN_TMR_CAP];
    st_next.sense.ethernet_link_status_in =
      st_reg.sync2[pfs_pkg::PIN_ETH_LINK] &
      sel_w[pfs_pkg::PIN_ETH_LINK];
    st_next.sense.ethernet_match_sense_in =
      st_reg.sync2[pfs_pkg::PIN_ETH_CAM] &
      sel_w[pfs_pkg::PIN_ETH_CAM];
    // Only power-on reset reaches the registers
    if (rst_i) begin
      st_next         = '0;
      st_next.func    = pfs_pkg::FUNC_RST;
      st_next.dir     = pfs_pkg::DIR_RST;
      st_next.pad_out = pfs_pkg::PAD_OUT_RST;
      st_next.pad_oe  = pfs_pkg::PAD_OE_RST;
      st_next.rdata   = pfs_pkg::RDATA_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    st_reg <= st_next;
  end

  // ***********************************************************************
  // Outputs
  // ***********************************************************************
  assign wb_dat_o  = st_reg.rdata;
  assign wb_ack_o  = st_reg.ack;
  assign pad_out_o = st_reg.pad_out;
  assign pad_oe_o  = st_reg.pad_oe;
  assign gpio_in_o = st_reg.gpio_in;
  assign sense_o   = st_reg.sense;

  // ***********************************************************************
  // Assertions
  // ***********************************************************************
  sequence seq_wb_req;
    wb_cyc_i && wb_stb_i && !st_reg.ack;
  endsequence

  sequence seq_func_wr_lo;
    seq_wb_req ##0 (wb_we_i && hit_func && wb_sel_i[0]);
  endsequence

  sequence seq_dir_wr_lo;
    seq_wb_req ##0 (wb_we_i && hit_dir && wb_sel_i[0]);
  endsequence

  sequence seq_dir_read;
    seq_wb_req ##0 (!wb_we_i && hit_dir);
  endsequence

  sequence seq_miss_read;
    seq_wb_req ##0 (!wb_we_i && !hit_func && !hit_dir);
  endsequence

  reset_clears_a: assert property (@(posedge clk_i)
    $fell(rst_i) |-> (st_reg.func == 16'h0000) &&
                     (st_reg.dir == 16'h0000) &&
                     (pad_oe_o == 14'h0088))
    else $error("registers not cleared by reset");

  func_reserved_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    seq_wb_req ##0 (wb_we_i && hit_func && wb_sel_i[1])
      |=> wb_ack_o && (st_reg.func[15:14] == 2'b00))
    else $error("reserved function bits stored");

  dir_reserved_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    seq_dir_wr_lo ##[2:4] seq_dir_read
      |=> (wb_dat_o[3] == 1'b0) && (wb_dat_o[31:14] == 18'h00000))
    else $error("reserved direction bits read back");

  func_write_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    seq_func_wr_lo |=> st_reg.func[7:0] == $past(wb_dat_i[7:0]))
    else $error("function low byte not written");

  dir_read_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    seq_dir_read |=> wb_ack_o &&
      (wb_dat_o == {16'h0000, $past(st_reg.dir)}))
    else $error("direction read data wrong");

  miss_read_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    seq_miss_read |=> wb_ack_o && (wb_dat_o == 32'h00000000))
    else $error("unmapped read not zero");

  ack_pulse_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");

  func_hold_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !(wb_req && wb_we_i && hit_func) |=> $stable(st_reg.func))
    else $error("function register changed without write");

  gpio_dir_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !sel_w[pfs_pkg::PIN_TMR_CMPA] |=>
      (pad_oe_o[4] == $past(st_reg.dir[4])) &&
      (pad_out_o[4] == $past(gpio_out_i[4])))
    else $error("general I/O pin 4 direction wrong");

  periph_ignore_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    sel_w[pfs_pkg::PIN_TX_DATA] |=> pad_oe_o[8] &&
      (pad_out_o[8] == $past(drive_i.serial_tx_data_out)))
    else $error("transmit data pin not driven");

  wdog_default_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !sel_w[pfs_pkg::PIN_WDOG] |=> pad_oe_o[7] &&
      (pad_out_o[7] == $past(drive_i.watchdog_overflow_out)))
    else $error("watchdog overflow not on pin 7");

  pin3_drive_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    sel_w[pfs_pkg::PIN_CLK_CMPB] ##1 sel_w[pfs_pkg::PIN_CLK_CMPB]
      |-> pad_oe_o[3] &&
          (pad_out_o[3] == $past(drive_i.timer_compare_out_b)))
    else $error("compare B not on pin 3");

  rx_data_path_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    $past(sel_w[pfs_pkg::PIN_RX_DATA]) |->
      sense_o.serial_rx_data_in == $past(pad_in_i[11], 3))
    else $error("receive data input path wrong");

  rx_data_gate_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !sel_w[pfs_pkg::PIN_RX_DATA] |=> !sense_o.serial_rx_data_in)
    else $error("receive data seen while deselected");

  rx_clk_gate_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !sel_w[pfs_pkg::PIN_RX_CLK] |=> !sense_o.serial_rx_clock_in)
    else $error("receive clock seen while deselected");

  rx_sync_gate_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !sel_w[pfs_pkg::PIN_RX_SYNC] |=> !sense_o.serial_rx_sync_in)
    else $error("receive sync seen while deselected");

  tx_clk_gate_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !sel_w[pfs_pkg::PIN_TX_CLK] |=> !sense_o.serial_tx_clock)
    else $error("transmit clock seen while deselected");

  tx_sync_gate_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !sel_w[pfs_pkg::PIN_TX_SYNC] |=> !sense_o.serial_tx_sync_in)
    else $error("transmit sync seen while deselected");

  tmr_clk_gate_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !sel_w[pfs_pkg::PIN_TMR_CLK] |=> !sense_o.timer_ext_clock_in)
    else $error("timer clock seen while deselected");

  tmr_cap_gate_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !sel_w[pfs_pkg::PIN_TMR_CAP] |=> !sense_o.timer_capture_in)
    else $error("timer capture seen while deselected");

  eth_link_gate_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !sel_w[pfs_pkg::PIN_ETH_LINK] |=> !sense_o.ethernet_link_status_in)
    else $error("link status seen while deselected");

  eth_cam_gate_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !sel_w[pfs_pkg::PIN_ETH_CAM] |=> !sense_o.ethernet_match_sense_in)
    else $error("match sense seen while deselected");

  tx_sync_drive_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    sel_w[pfs_pkg::PIN_TX_SYNC] |=>
      (pad_oe_o[9] == $past(drive_i.serial_tx_sync_oe)) &&
      (pad_out_o[9] == $past(drive_i.serial_tx_sync_out)))
    else $error("transmit sync pin not under peripheral");

  cmpa_drive_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    sel_w[pfs_pkg::PIN_TMR_CMPA] |=> pad_oe_o[4] &&
      (pad_out_o[4] == $past(drive_i.timer_compare_out_a)))
    else $error("compare A not on pin 4");

  eth_out_drive_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    sel_w[pfs_pkg::PIN_ETH_OUT] |=> pad_oe_o[1] &&
      (pad_out_o[1] == $past(drive_i.ethernet_general_out)))
    else $error("general output not on pin 1");

  clk_out_drive_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !sel_w[pfs_pkg::PIN_CLK_CMPB] |=> pad_oe_o[3] &&
      (pad_out_o[3] == $past(drive_i.peripheral_clock_out)))
    else $error("clock output not on pin 3");

  rx_pin_quiet_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    sel_w[pfs_pkg::PIN_RX_DATA] |=> !pad_oe_o[11])
    else $error("receive data pin driven");

  wdog_gpio_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    sel_w[pfs_pkg::PIN_WDOG] |=> pad_oe_o[7] == $past(st_reg.dir[7]))
    else $error("pin 7 general I/O direction wrong");

  dir_write_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    seq_dir_wr_lo |=> st_reg.dir[7:0] ==
      ($past(wb_dat_i[7:0]) & pfs_pkg::DIR_WMASK[7:0]))
    else $error("direction low byte not written");

  dir_hold_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !(wb_req && wb_we_i && hit_dir) |=> $stable(st_reg.dir))
    else $error("direction register changed without write");

endmodule

// ===== tb/pfs_pin_partner.sv
// Peripheral and pad model on the far side of the pin function select
`timescale 1ns/100ps
module pfs_pin_partner (
  input  wire logic                  clk_i,
  input  wire logic [13:0]           pad_out_i,
  input  wire logic [13:0]           pad_oe_i,
  input  wire logic [13:0]           ext_level_i,
  input  wire logic [7:0]            drive_pattern_i,
  output logic      [13:0]           pad_in_o,
  output pfs_pkg::pfs_periph_drive_s drive_o
);
  // ***********************************************************************
  // Pads: the chip wins where it drives, the board level elsewhere
  // ***********************************************************************
  assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_level_i);

  // ***********************************************************************
  // Peripheral outputs, launched on the shared clock like real logic
  // ***********************************************************************
  always_ff @(posedge clk_i) begin
    drive_o <= drive_pattern_i;
  end
endmodule

// ===== tb/pfs_pin_select_tb_top.sv
// Self-checking bench for the port A pin function select
`timescale 1ns/100ps
module pfs_pin_select_tb_top;
  logic                        clk_i = 1'b0;
  logic                        rst_i = 1'b1;
  logic                        wb_cyc, wb_stb, wb_we, wb_ack;
  logic [31:0]                 wb_adr, wb_dat_w, wb_dat_r;
  logic [3:0]                  wb_sel;
  logic [13:0]                 pad_in, pad_out, pad_oe, gout, gin, ext;
  logic [7:0]                  dpat;
  pfs_pkg::pfs_periph_drive_s  drive;
  pfs_pkg::pfs_periph_sense_s  sense;
  logic [31:0]                 q;
  int                          err_count = 0;
  int                          n_compared = 0;
  localparam logic [15:0] TF [4] = '{16'h0000, 16'h3FFF, 16'h2AAA, 16'h1555};
  localparam logic [15:0] TD [4] = '{16'h3FF7, 16'h3FF7, 16'h1555, 16'h2AA2};
  localparam logic [13:0] TG [4] = '{14'h2AAA, 14'h1555, 14'h3FFF, 14'h0000};
  localparam logic [13:0] TE [4] = '{14'h1555, 14'h2AAA, 14'h0000, 14'h3FFF};
  localparam logic [7:0]  TP [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};

  always #4 clk_i = ~clk_i;

  pfs_pin_select DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
    .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
    .gpio_out_i(gout), .gpio_in_o(gin), .drive_i(drive), .sense_o(sense));

  pfs_pin_partner u_partner (.clk_i(clk_i), .pad_out_i(pad_out),
    .pad_oe_i(pad_oe), .ext_level_i(ext), .drive_pattern_i(dpat),
    .pad_in_o(pad_in), .drive_o(drive));

  // ***********************************************************************
  // Bus and compare helpers
  // ***********************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (e !== g) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic cycle; no fixed latency assumed, bounded wait only
  task automatic wb_xfer(input logic [31:0] a, input logic w,
                         input logic [15:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= w;
    wb_adr   <= a;
    wb_sel   <= s;
    wb_dat_w <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 40);
    q = wb_dat_r;
    if (n >= 40) begin
      err_count++;
      $display("[ERR] wb_ack expected 1 seen %b", wb_ack);
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [15:0] e, input string nm);
    wb_xfer(a, 1'b0, 16'h0000, 4'h3);
    chk(nm, {16'h0000, e}, q);
  endtask

  // Expected pad and sense view worked out per pin
  task automatic check_pins(input logic [15:0] f, input logic [15:0] d,
      input logic [13:0] go, input logic [13:0] ex, input logic [7:0] dv);
    logic [13:0] eoe, eout, pad;
    logic [8:0]  es;
    logic        per;
    for (int i = 0; i < 14; i++) begin
      per = (i == 7) ? !f[7] : f[i];
      eoe[i] = d[i];
      eout[i] = go[i];
      if (per || i == 3) begin
        eoe[i] = 1'b0;
        eout[i] = 1'b0;
        case (i)
          9: begin eoe[i] = dv[6]; eout[i] = dv[7]; end
          8: begin eoe[i] = 1'b1; eout[i] = dv[5]; end
          7: begin eoe[i] = 1'b1; eout[i] = dv[4]; end
          4: begin eoe[i] = 1'b1; eout[i] = dv[3]; end
          3: begin eoe[i] = 1'b1; eout[i] = f[3] ? dv[2] : dv[1]; end
          1: begin eoe[i] = 1'b1; eout[i] = dv[0]; end
          default: ;
        endcase
      end
      pad[i] = eoe[i] ? eout[i] : ex[i];
    end
    es = {pad[13:9] & f[13:9], pad[6:5] & f[6:5], pad[2] & f[2], pad[0] & f[0]};
    chk("pad_oe", 32'(eoe), 32'(pad_oe));
    chk("pad_out", 32'(eout & eoe), 32'(pad_out & pad_oe));
    chk("gpio_in", 32'(pad), 32'(gin));
    chk("sense", 32'(es), 32'(sense));
  endtask

  task automatic end_of_test();
    if (err_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ***********************************************************************
  // Test sequence
  // ***********************************************************************
  initial begin
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w} = '0;
    {gout, ext, dpat} = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("pad_oe_rst", 32'h00000088, 32'(pad_oe));
    rd_chk(pfs_pkg::FUNC_ADDR, 16'h0000, "func_rst");
    rd_chk(pfs_pkg::DIR_ADDR, 16'h0000, "dir_rst");
    wb_xfer(pfs_pkg::FUNC_ADDR, 1'b1, 16'hFFFF, 4'h3);
    rd_chk(pfs_pkg::FUNC_ADDR, 16'h3FFF, "func_rw");
    wb_xfer(pfs_pkg::DIR_ADDR, 1'b1, 16'hFFFF, 4'h3);
    rd_chk(pfs_pkg::DIR_ADDR, 16'h3FF7, "dir_rw");
    wb_xfer(pfs_pkg::FUNC_ADDR, 1'b1, 16'h0000, 4'h2);
    rd_chk(pfs_pkg::FUNC_ADDR, 16'h00FF, "func_hi_byte");
    wb_xfer(pfs_pkg::FUNC_ADDR, 1'b1, 16'h0000, 4'h1);
    rd_chk(pfs_pkg::FUNC_ADDR, 16'h0000, "func_lo_byte");
    wb_xfer(pfs_pkg::FUNC_ADDR + 32'h10, 1'b1, 16'hFFFF, 4'h3);
    rd_chk(pfs_pkg::FUNC_ADDR + 32'h10, 16'h0000, "unmapped");
    rd_chk(pfs_pkg::FUNC_ADDR, 16'h0000, "func_kept");
    for (int k = 0; k < 4; k++) begin
      wb_xfer(pfs_pkg::FUNC_ADDR, 1'b1, TF[k], 4'h3);
      wb_xfer(pfs_pkg::DIR_ADDR, 1'b1, TD[k], 4'h3);
      gout <= TG[k];
      ext  <= TE[k];
      dpat <= TP[k];
      // Covers partner launch, pad output register, two sync flops and input register
      repeat (6) @(posedge clk_i);
      check_pins(TF[k], TD[k], TG[k], TE[k], TP[k]);
    end
    // Second reset in mid-run clears both registers again
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("pad_oe_por", 32'h00000088, 32'(pad_oe));
    rd_chk(pfs_pkg::FUNC_ADDR, 16'h0000, "func_por");
    rd_chk(pfs_pkg::DIR_ADDR, 16'h0000, "dir_por");
    end_of_test();
  end

  // Whole sequence needs about one hundred twenty cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    $display("[ERR] watchdog expected done seen hang");
    end_of_test();
  end
endmodule
